// ### design/eeprom_access_consts.vh
// constants for the eeprom access controller
`ifndef EEPROM_ACCESS_CONSTS_VH
`define EEPROM_ACCESS_CONSTS_VH

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define EE_OFS_CONTROL    8'h00
`define EE_OFS_ADDRESS    8'h04
`define EE_OFS_DATA       8'h08
`define EE_OFS_STATUS     8'h0C

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define EE_BIT_READ       0
`define EE_BIT_WRITE      1
`define EE_BIT_ARM        2
`define EE_CTRL_RESET     8'h00
`define EE_ADDR_RESET     7'h00
`define EE_DATA_RESET     8'h00

// ------------------------------------------------------------
// status register fields
// ------------------------------------------------------------
`define EE_STAT_BUSY      0
`define EE_STAT_ABORT     1
`define EE_STAT_STALL     2

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define EE_CLK_MHZ        250
`define EE_ARM_CYCLES     4
`define EE_WR_STALL       2
`define EE_RD_STALL       4
`define EE_WRITE_TIME_US  2500
`define EE_WRITE_CYCLES   (`EE_WRITE_TIME_US * `EE_CLK_MHZ)
`define EE_DEPTH          128

`endif

// ### design/eeprom_access_control.v
// eeprom access controller with ahb-lite register slave
//
// Notes on behaviour
// - strobe writes only while arm bit set
// - arm bit self-clears four cycles later
// - write strobe held until timed write ends
// - write strobe stalls processor two cycles
// - read strobe fetches byte, then self-clears
// - read strobe stalls processor four cycles
// - address or data write aborts write
// - control bits 7..3 read as zero
`timescale 1ns/1ns
`include "eeprom_access_consts.vh"
module eeprom_access_control #(
  parameter WRITE_CYCLES = `EE_WRITE_CYCLES
) (
  // clock and reset
  input  wire        sys_clk_in,
  input  wire        rst_in,
  // ahb-lite slave
  input  wire        hsel_in,
  input  wire [31:0] haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire [31:0] hwdata_in,
  input  wire        hready_in,
  output reg  [31:0] hrdata_out,
  output reg         hreadyout_out,
  output reg         hresp_out,
  // processor stall and status
  output reg         cpu_stall_out,
  output reg         write_busy_out
);

  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  localparam ST_IDLE  = 2'd0;
  localparam ST_WRITE = 2'd1;
  localparam ST_READ  = 2'd2;

  reg  [1:0]  state_r;
  reg         arm_r;
  reg  [2:0]  arm_cnt_r;
  reg         wr_strobe_r;
  reg         rd_strobe_r;
  reg  [6:0]  addr_r;
  reg  [7:0]  data_r;
  reg  [31:0] wr_cnt_r;
  reg  [2:0]  stall_cnt_r;
  reg         abort_r;
  reg         ap_valid_r;
  reg         ap_write_r;
  reg  [7:0]  ap_addr_r;
  reg         cell_wr_r;
  reg         rd_wait_r;
  reg  [31:0] hrdata_nxt;
  reg  [2:0]  stall_cnt_nxt;
  reg         cpu_stall_nxt;
  wire [7:0]  cell_rd_data;

  // counter end points, cut to the widths of their counters
  localparam integer ARM_LAST_I  = `EE_ARM_CYCLES - 1;
  localparam integer WR_STALL_I  = `EE_WR_STALL - 1;
  localparam integer RD_STALL_I  = `EE_RD_STALL - 1;
  localparam [2:0]   ARM_LAST    = ARM_LAST_I[2:0];
  localparam [2:0]   WR_STALL_LD = WR_STALL_I[2:0];
  localparam [2:0]   RD_STALL_LD = RD_STALL_I[2:0];
  localparam [31:0]  WR_LAST     = WRITE_CYCLES - 1;

  // ahb address phase qualifier
  wire ap_take = hsel_in & hready_in & htrans_in[1];
  // data phase write decode
  wire dp_wr   = ap_valid_r & ap_write_r & hreadyout_out;
  wire wr_ctrl = dp_wr & (ap_addr_r == `EE_OFS_CONTROL);
  wire wr_addr = dp_wr & (ap_addr_r == `EE_OFS_ADDRESS);
  wire wr_data = dp_wr & (ap_addr_r == `EE_OFS_DATA);
  // arm and strobe requests carried by a control write
  wire set_arm = wr_ctrl & hwdata_in[`EE_BIT_ARM] & ~hwdata_in[`EE_BIT_WRITE];
  wire set_wr  = wr_ctrl & hwdata_in[`EE_BIT_WRITE] & ~wr_strobe_r;
  wire set_rd  = wr_ctrl & hwdata_in[`EE_BIT_READ] & ~wr_strobe_r & ~rd_strobe_r;
  wire start_wr = set_wr & arm_r & (state_r == ST_IDLE);

  // byte offset of the word that an address selects
  function [7:0] word_offset;
    input [31:0] addr;
    begin
      word_offset = {addr[7:2], 2'b00};
    end
  endfunction

  // status register readback
  function [31:0] status_word;
    input s;
    input ab;
    input b;
    begin
      status_word = {29'd0, s, ab, b};
    end
  endfunction

  // control register readback
  function [31:0] ctrl_word;
    input a;
    input w;
    input r;
    begin
      ctrl_word = {29'd0, a, w, r};
    end
  endfunction

  // ----------------------------------------------------------
  // ahb address phase capture
  // ----------------------------------------------------------
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ap_valid_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_addr_r  <= 8'h00;
    end else if (hready_in) begin
      ap_valid_r <= ap_take;
      ap_write_r <= hwrite_in;
      ap_addr_r  <= word_offset(haddr_in);
    end
  end

  // ----------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------
  // word for the read address phase being taken
  always @* begin
    hrdata_nxt = 32'h0000_0000;
    case (word_offset(haddr_in))
      `EE_OFS_CONTROL: hrdata_nxt = ctrl_word(arm_r, wr_strobe_r, rd_strobe_r);
      `EE_OFS_ADDRESS: hrdata_nxt = {25'd0, addr_r};
      `EE_OFS_DATA:    hrdata_nxt = {24'd0, data_r};
      `EE_OFS_STATUS:  hrdata_nxt = status_word(cpu_stall_out, abort_r, wr_strobe_r);
      default:         hrdata_nxt = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------
  // read data and response
  // ----------------------------------------------------------
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      hrdata_out    <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      if (ap_take & ~hwrite_in) begin
        hrdata_out <= hrdata_nxt;
      end
    end
  end

  // ----------------------------------------------------------
  // arm bit with four cycle expiry
  // ----------------------------------------------------------
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      arm_r     <= 1'b0;
      arm_cnt_r <= 3'd0;
    end else if (set_arm) begin
      arm_r     <= 1'b1;
      arm_cnt_r <= 3'd0;
    end else if (start_wr) begin
      arm_r     <= 1'b0;  // consumed by the write
    end else if (arm_r) begin
      if (arm_cnt_r == ARM_LAST) begin
        arm_r <= 1'b0;
      end
      arm_cnt_r <= arm_cnt_r + 3'd1;
    end
  end

  // ----------------------------------------------------------
  // address and data registers
  // ----------------------------------------------------------
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      addr_r <= `EE_ADDR_RESET;
      data_r <= `EE_DATA_RESET;
    end else begin
      if (wr_addr) begin
        addr_r <= hwdata_in[6:0];
      end
      if (wr_data) begin
        data_r <= hwdata_in[7:0];
      end else if (rd_wait_r) begin
        data_r <= cell_rd_data;
      end
    end
  end

  // ----------------------------------------------------------
  // write and read sequencer
  // ----------------------------------------------------------
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r     <= ST_IDLE;
      wr_strobe_r <= 1'b0;
      rd_strobe_r <= 1'b0;
      wr_cnt_r    <= 32'd0;
      abort_r     <= 1'b0;
      cell_wr_r   <= 1'b0;
      rd_wait_r   <= 1'b0;
    end else begin
      cell_wr_r <= 1'b0;
      rd_wait_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (start_wr) begin
            state_r     <= ST_WRITE;
            wr_strobe_r <= 1'b1;
            wr_cnt_r    <= 32'd0;
            abort_r     <= 1'b0;
          end else if (set_rd) begin
            state_r     <= ST_READ;
            rd_strobe_r <= 1'b1;
          end
        end
        ST_WRITE: begin
          if (wr_addr | wr_data) begin
            state_r     <= ST_IDLE;
            wr_strobe_r <= 1'b0;
            abort_r     <= 1'b1;
          end else if (wr_cnt_r == WR_LAST) begin
            state_r     <= ST_IDLE;
            wr_strobe_r <= 1'b0;
            cell_wr_r   <= 1'b1;
          end else begin
            wr_cnt_r <= wr_cnt_r + 32'd1;
          end
        end
        ST_READ: begin
          state_r     <= ST_IDLE;
          rd_strobe_r <= 1'b0;
          rd_wait_r   <= 1'b1;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------
  // processor stall counter
  // ----------------------------------------------------------
  // next stall state: load on a strobe, count down, drop at zero
  always @* begin
    stall_cnt_nxt = stall_cnt_r;
    cpu_stall_nxt = cpu_stall_out;
    if (start_wr) begin
      stall_cnt_nxt = WR_STALL_LD;
      cpu_stall_nxt = 1'b1;
    end else if (set_rd & (state_r == ST_IDLE)) begin
      stall_cnt_nxt = RD_STALL_LD;
      cpu_stall_nxt = 1'b1;
    end else if (stall_cnt_r != 3'd0) begin
      stall_cnt_nxt = stall_cnt_r - 3'd1;
    end else begin
      cpu_stall_nxt = 1'b0;
    end
  end

  // stall count and stall output registers
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      stall_cnt_r   <= 3'd0;
      cpu_stall_out <= 1'b0;
    end else begin
      stall_cnt_r   <= stall_cnt_nxt;
      cpu_stall_out <= cpu_stall_nxt;
    end
  end

  // ----------------------------------------------------------
  // write busy flag
  // ----------------------------------------------------------
  // busy flag follows the write strobe one cycle late, but drops in the same cycle on an abort
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      write_busy_out <= 1'b0;
    end else begin
      write_busy_out <= (state_r == ST_WRITE) & ~(wr_addr | wr_data);
    end
  end

  // ----------------------------------------------------------
  // storage array
  // ----------------------------------------------------------
  eeprom_cell_array u_cells (
    .sys_clk_in  (sys_clk_in),
    .wr_en_in    (cell_wr_r),
    .wr_addr_in  (addr_r),
    .wr_data_in  (data_r),
    .rd_addr_in  (addr_r),
    .rd_data_out (cell_rd_data)
  );

endmodule

// ### design/eeprom_cell_array.v
// 128 byte storage array with one-cycle read
`timescale 1ns/1ns
module eeprom_cell_array (
  // clock
  input  wire       sys_clk_in,
  // write port
  input  wire       wr_en_in,
  input  wire [6:0] wr_addr_in,
  input  wire [7:0] wr_data_in,
  // read port
  input  wire [6:0] rd_addr_in,
  output reg  [7:0] rd_data_out
);

  reg [7:0] cells [0:127];

  // ----------------------------------------------------------
  // storage
  // ----------------------------------------------------------
  // synchronous write and registered read
  always @(posedge sys_clk_in) begin
    if (wr_en_in) begin
      cells[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= cells[rd_addr_in];
  end

endmodule

// ### verif/eeprom_access_control_props.sv
// assertion checker for the eeprom access controller
`timescale 1ns/1ns
module eeprom_access_control_props #(
  parameter WRITE_CYCLES = 20
) (
  // clock, reset and bus request
  input wire        sys_clk_in,
  input wire        rst_in,
  input wire        hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0]  htrans_in,
  input wire        hwrite_in,
  input wire        hready_in,
  input wire [31:0] hwdata_in,
  // answers and status
  input wire [31:0] hrdata_out,
  input wire        hreadyout_out,
  input wire        hresp_out,
  input wire        cpu_stall_out,
  input wire        write_busy_out
);
  // ------------------------------------------------------------
  // data phase flags, abort memory and run counters
  // ------------------------------------------------------------
  logic        ctl_wr_r;
  logic        ctl_rd_r;
  logic        abort_r;
  logic [31:0] stall_len_r;
  logic [31:0] busy_len_r;
  logic [2:0]  arm_age_r;
  logic        arm_ok_r;
  wire         take = hsel_in & hready_in & htrans_in[1];
  wire         adr_hit = (haddr_in[7:0] == 8'h04) | (haddr_in[7:0] == 8'h08);
  // track control accesses and writes that cut a running write short
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctl_wr_r    <= 1'b0;
      ctl_rd_r    <= 1'b0;
      abort_r     <= 1'b0;
      stall_len_r <= 32'h0000_0000;
      busy_len_r  <= 32'h0000_0000;
      arm_age_r   <= 3'd0;
      arm_ok_r    <= 1'b0;
    end else begin
      ctl_wr_r    <= take & hwrite_in & (haddr_in[7:0] == 8'h00);
      ctl_rd_r    <= take & !hwrite_in & (haddr_in[7:0] == 8'h00);
      abort_r     <= write_busy_out & (abort_r | (take & hwrite_in & adr_hit));
      stall_len_r <= cpu_stall_out ? stall_len_r + 1 : 32'h0000_0000;
      busy_len_r  <= write_busy_out ? busy_len_r + 1 : 32'h0000_0000;
      // age of the last arm write, counted from its data phase
      arm_ok_r    <= (arm_age_r != 3'd0) && (arm_age_r <= 3'd4);
      if (ctl_wr_r && hwdata_in[2] && !hwdata_in[1]) begin
        arm_age_r <= 3'd1;
      end else if (arm_age_r != 3'd0 && arm_age_r != 3'd7) begin
        arm_age_r <= arm_age_r + 3'd1;
      end
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  a_ready_high: assert property (hreadyout_out)
    else $error("wait state inserted");
  a_resp_okay: assert property (!hresp_out)
    else $error("error response");
  a_ctrl_reserved: assert property (ctl_rd_r |-> hrdata_out[31:3] == 29'h0000_0000)
    else $error("reserved control bits not zero");
  a_arm_first: assert property ($rose(write_busy_out) |-> $past(ctl_wr_r) || $past(ctl_wr_r, 2))
    else $error("write started without control write");
  a_stall_cause: assert property ($rose(cpu_stall_out) |-> $past(ctl_wr_r) || $past(ctl_wr_r, 2))
    else $error("stall without strobe");
  a_stall_len: assert property ($fell(cpu_stall_out) |-> stall_len_r == 2 || stall_len_r == 4)
    else $error("stall length wrong");
  a_busy_len: assert property ($fell(write_busy_out) |-> busy_len_r == WRITE_CYCLES || abort_r)
    else $error("write time wrong");
  a_abort_stop: assert property (take && hwrite_in && adr_hit && write_busy_out
    |-> ##[1:4] !write_busy_out)
    else $error("write not aborted");
  a_arm_window: assert property ($rose(write_busy_out) |-> $past(arm_ok_r))
    else $error("write started outside arm window");
  cover property ($fell(write_busy_out) && abort_r);
  cover property ($fell(write_busy_out) && !abort_r);
  cover property ($fell(cpu_stall_out) && stall_len_r == 4);
endmodule
bind eeprom_access_control eeprom_access_control_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (.*);

// ### verif/eeprom_access_control_test.sv
// self-checking testbench for the eeprom access controller
`timescale 1ns/1ns
module eeprom_access_control_test;
  logic        sys_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        hsel_in = 1'b0;
  logic        hwrite_in = 1'b0;
  logic [1:0]  htrans_in = 2'b00;
  logic [31:0] haddr_in = 32'h0000_0000;
  logic [31:0] hwdata_in = 32'h0000_0000;
  wire  [31:0] hrdata_out;
  wire         hreadyout_out, hresp_out, cpu_stall_out, write_busy_out;
  logic [31:0] q;
  int          err_total = 0, compares = 0, cyc = 0;
  // rows: offset, value written, byte read back
  logic [47:0] rows [0:4] = '{{8'h04, 32'hffff_ffff, 8'h7f}, {8'h08, 32'h1234_56a5, 8'ha5},
    {8'h00, 32'hffff_fff8, 8'h00}, {8'h10, 32'h0000_00ff, 8'h00}, {8'h00, 32'h0000_0002, 8'h00}};
  always #2 sys_clk_in = ~sys_clk_in;
  eeprom_access_control #(.WRITE_CYCLES(20)) u_eeprom_access_control (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'b010), .hwdata_in(hwdata_in),
    .hready_in(hreadyout_out), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .cpu_stall_out(cpu_stall_out), .write_busy_out(write_busy_out));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one single ahb-lite transfer, address phase then data phase
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel_in <= 1'b1;
    htrans_in <= 2'b10;
    hwrite_in <= w;
    haddr_in <= {24'h00_0000, a};
    do @(posedge sys_clk_in); while (hreadyout_out !== 1'b1);
    htrans_in <= 2'b00;
    hwdata_in <= d;
    do @(posedge sys_clk_in); while (hreadyout_out !== 1'b1);
    q = hrdata_out;
  endtask
  task wait_clk(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  task wrap_up;
    $display("mismatches %0d of %0d compares", err_total, compares);
    if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total++;
      wrap_up;
    end
  end
  initial begin
    wait_clk(12);
    rst_in <= 1'b0;
    wait_clk(1);
    for (int i = 0; i < 3; i++) begin
      bus(0, 8'(i * 4), 0);
      chk(q, 32'h0000_0000);
    end
    foreach (rows[i]) begin
      bus(1, rows[i][47:40], rows[i][39:8]);
      bus(0, rows[i][47:40], 0);
      chk(q, {24'h00_0000, rows[i][7:0]});
    end
    // armed write, then read the byte back
    bus(1, 8'h04, 32'h0000_0005);
    bus(1, 8'h08, 32'h0000_003c);
    bus(1, 8'h00, 32'h0000_0004);
    bus(1, 8'h00, 32'h0000_0002);
    wait_clk(1);
    chk(cpu_stall_out, 1);
    bus(0, 8'h00, 0);
    chk(q, 32'h0000_0002);
    chk(cpu_stall_out, 0);
    wait_clk(10);
    chk(write_busy_out, 1);
    for (int n = 0; n < 40 && q[1] !== 1'b0; n++) bus(0, 8'h00, 0);
    chk(q, 32'h0000_0000);
    bus(1, 8'h08, 32'h0000_0000);
    bus(1, 8'h00, 32'h0000_0001);
    bus(0, 8'h00, 0);
    chk(q, 32'h0000_0001);
    chk(cpu_stall_out, 1);
    bus(0, 8'h08, 0);
    chk(q, 32'h0000_003c);
    chk(cpu_stall_out, 1);
    bus(0, 8'h00, 0);
    chk(q, 32'h0000_0000);
    chk(cpu_stall_out, 0);
    // arm left to expire
    bus(1, 8'h00, 32'h0000_0004);
    bus(0, 8'h00, 0);
    chk(q, 32'h0000_0004);
    wait_clk(6);
    bus(0, 8'h00, 0);
    chk(q, 32'h0000_0000);
    bus(1, 8'h00, 32'h0000_0002);
    wait_clk(3);
    chk(write_busy_out, 0);
    // address write in mid-write
    bus(1, 8'h00, 32'h0000_0004);
    bus(1, 8'h00, 32'h0000_0002);
    wait_clk(4);
    chk(write_busy_out, 1);
    bus(1, 8'h04, 32'h0000_0009);
    wait_clk(4);
    chk(write_busy_out, 0);
    bus(0, 8'h0c, 0);
    chk(q & 32'h0000_0002, 32'h0000_0002);
    // reset during a write
    bus(1, 8'h00, 32'h0000_0004);
    bus(1, 8'h00, 32'h0000_0002);
    rst_in <= 1'b1;
    wait_clk(2);
    rst_in <= 1'b0;
    wait_clk(1);
    chk(write_busy_out, 0);
    chk(cpu_stall_out, 0);
    bus(0, 8'h00, 0);
    chk(q, 32'h0000_0000);
    wrap_up;
  end
endmodule
